/* rtl/odac_defs.vh */
// constants for the octal dac two-wire command port
// included by the command port and its register memory
`ifndef ODAC_DEFS_VH
`define ODAC_DEFS_VH
`define ODAC_ADDR_HI 5'h03
`define ODAC_CMD_NOP 4'h0
`define ODAC_CMD_WR_IN 4'h1
`define ODAC_CMD_UPD 4'h2
`define ODAC_CMD_WR_UPD 4'h3
`define ODAC_CMD_PWR 4'h4
`define ODAC_CMD_MASK 4'h5
`define ODAC_CMD_RDBK 4'h9
`define ODAC_PM_NORMAL 2'h0
`define ODAC_PM_1K 2'h1
`define ODAC_PM_TRI 2'h3
`define ODAC_CMD_MSB 23
`define ODAC_ADR_MSB 19
`define ODAC_DAT_MSB 15
`endif

/* rtl/odac_regmem.v */
// input register bank for eight channels, registered read port
// assumes one writer and one reader in the SYS_CLK domain
`timescale 1ns/1ns
`include "odac_defs.vh"
module odac_regmem #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
      rdata <= {WIDTH{1'b0}};
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

/* rtl/odac_i2c_port.v */
// two-wire command port of an eight channel dac, slave side
// assumes SCL and SDA inputs already synchronous to SYS_CLK
//
// Overview of operation
// - command 1 writes input register; transparent when strobe low, unmasked
// - command 2 copies input to dac register for channels set in D7..D0
// - command 3 writes dac register of addressed channel at once
// - answer address 00011 plus the two address select pins
// - acknowledge own address by pulling SDA low on ninth pulse
// - nine pulses per byte; SDA changes only while SCL low
// - write is address, command, data high, data low, each acked
// - after repeated start, read address acked, input data driven
// - readback selecting several channels returns channel 0
// - read each register msb first, advance pointer, wrap 7 to 0
// - command 4 takes sixteen bits as eight two bit power fields
// - power field 00 normal, 01 one kilohm to ground, 11 tristate
// - dac registers kept and still writable while powered down
// - two banks per channel; dac loads governed by load strobe
// - strobe low during command 1 loads both registers at frame end
// - frame is command, address, sixteen bit data, msb first
// - strobe falling edge copies input to dac registers when high
// - command 5 loads per channel mask; masked channels ignore strobe
`timescale 1ns/1ns
`include "odac_defs.vh"
module odac_i2c_port #(
  parameter DW = 16,
  parameter NCH = 8
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire ADDR_SELECT_PIN_HI,
  input wire ADDR_SELECT_PIN_LO,
  input wire LOAD_STROBE_N,
  output reg [NCH*DW-1:0] DAC_CODE,
  output reg [2*NCH-1:0] POWER_MODE,
  output reg [NCH-1:0] OUT_GND_1K,
  output reg [NCH-1:0] OUT_TRISTATE,
  output reg [NCH-1:0] LOAD_MASK
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WRB = 3'h2;
  localparam ST_RDB = 3'h3;
  localparam ST_SKIP = 3'h4;

  reg [2:0] state;
  reg scl_d;
  reg sda_d;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [1:0] bytecnt;
  reg [23:0] frame;
  reg is_read;
  reg ack_phase;
  reg [2:0] rd_ptr;
  reg rd_lo;
  reg [7:0] tx_byte;
  reg ld_d;
  reg frame_go;
  reg [NCH-1:0] copy_more;
  reg in_we;
  reg [2:0] in_waddr;
  reg [DW-1:0] in_wdata;
  reg [2:0] copy_ch;
  reg copy_pend;
  reg [NCH-1:0] copy_set;
  wire [DW-1:0] in_rdata;
  wire scl_rise = SCL_IN & ~scl_d;
  wire scl_fall = ~SCL_IN & scl_d;
  // start and stop only seen with SCL high
  wire start_c = scl_d & SCL_IN & sda_d & ~SDA_IN;
  wire stop_c = scl_d & SCL_IN & ~sda_d & SDA_IN;
  wire ld_fall = ld_d & ~LOAD_STROBE_N;
  wire [3:0] f_cmd = frame[`ODAC_CMD_MSB:`ODAC_CMD_MSB-3];
  wire [3:0] f_adr = frame[`ODAC_ADR_MSB:`ODAC_ADR_MSB-3];
  wire [DW-1:0] f_dat = frame[`ODAC_DAT_MSB:0];
  wire [7:0] f_sel = f_dat[7:0];
  wire [6:0] my_addr = {`ODAC_ADDR_HI, ADDR_SELECT_PIN_HI, ADDR_SELECT_PIN_LO};
  // strobe fall asks for every unmasked channel
  wire [NCH-1:0] ld_req = ld_fall ? ~LOAD_MASK : {NCH{1'b0}};
  // command 2 asks for the channels set in D7..D0
  wire upd_go = frame_go && f_cmd == `ODAC_CMD_UPD;
  wire [NCH-1:0] upd_req = upd_go ? f_sel : {NCH{1'b0}};
  wire [NCH-1:0] copy_req = ld_req | upd_req;

  // copy engine borrows the read port; avoid strobing during a readback
  odac_regmem #(.WIDTH(DW), .DEPTH(NCH), .AW(3)) u_inreg (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .we(in_we),
    .waddr(in_waddr),
    .wdata(in_wdata),
    .raddr(copy_pend ? copy_ch : rd_ptr),
    .rdata(in_rdata)
  );

  // serial engine: bits shift in on SCL rise, drive changes on SCL fall
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      bytecnt <= 2'h0;
      frame <= 24'h000000;
      is_read <= 1'b0;
      ack_phase <= 1'b0;
      rd_ptr <= 3'h0;
      rd_lo <= 1'b0;
      tx_byte <= 8'h00;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      frame_go <= 1'b0;
    end else begin
      scl_d <= SCL_IN;
      sda_d <= SDA_IN;
      frame_go <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        SDA_OE <= 1'b0;
        bytecnt <= 2'h0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        SDA_OE <= 1'b0;
      end else if (state != ST_IDLE && state != ST_SKIP) begin
        if (scl_rise && !ack_phase) begin
          shreg <= {shreg[6:0], SDA_IN};
          bitcnt <= bitcnt + 4'h1;
        end
        if (scl_rise && ack_phase && state == ST_RDB) begin
          if (SDA_IN) begin
            state <= ST_SKIP;
          end
        end
        if (scl_fall) begin
          if (!ack_phase && bitcnt == 4'h8) begin
            ack_phase <= 1'b1;
            bitcnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == my_addr) begin
                SDA_OE <= 1'b1;
                SDA_OUT <= 1'b0;
                is_read <= shreg[0];
              end else begin
                state <= ST_SKIP;
                SDA_OE <= 1'b0;
              end
            end else if (state == ST_WRB) begin
              SDA_OE <= 1'b1;
              SDA_OUT <= 1'b0;
              frame <= {frame[15:0], shreg};
              if (bytecnt == 2'h2) begin
                bytecnt <= 2'h0;
                frame_go <= 1'b1;
              end else begin
                bytecnt <= bytecnt + 2'h1;
              end
            end else begin
              SDA_OE <= 1'b0;
            end
          end else if (!ack_phase && state == ST_RDB) begin
            // bit 7 went out at the ack fall, so drive the next one
            SDA_OE <= ~tx_byte[6];
            SDA_OUT <= 1'b0;
            tx_byte <= {tx_byte[6:0], 1'b1};
          end else if (ack_phase) begin
            ack_phase <= 1'b0;
            SDA_OE <= 1'b0;
            // read address acked, then data driven
            if (state == ST_ADDR) begin
              state <= is_read ? ST_RDB : ST_WRB;
            end
            if (state == ST_RDB || (state == ST_ADDR && is_read)) begin
              // msb byte then lsb byte, pointer wraps
              tx_byte <= rd_lo ? in_rdata[7:0] : in_rdata[15:8];
              SDA_OE <= rd_lo ? ~in_rdata[7] : ~in_rdata[15];
              SDA_OUT <= 1'b0;
              if (rd_lo) begin
                rd_ptr <= rd_ptr + 3'h1;
              end
              rd_lo <= ~rd_lo;
            end
          end
        end
      end
      // readback pointer, several channels give channel 0
      if (frame_go && f_cmd == `ODAC_CMD_RDBK) begin
        rd_ptr <= f_adr[3] ? 3'h0 : f_adr[2:0];
        rd_lo <= 1'b0;
      end
    end
  end

  // register banks and frame execution
  integer k;
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DAC_CODE <= {NCH*DW{1'b0}};
      POWER_MODE <= {2*NCH{1'b0}};
      OUT_GND_1K <= {NCH{1'b0}};
      OUT_TRISTATE <= {NCH{1'b0}};
      LOAD_MASK <= {NCH{1'b0}};
      ld_d <= 1'b1;
      in_we <= 1'b0;
      in_waddr <= 3'h0;
      in_wdata <= {DW{1'b0}};
      copy_pend <= 1'b0;
      copy_set <= {NCH{1'b0}};
      copy_ch <= 3'h0;
      copy_more <= {NCH{1'b0}};
    end else begin
      ld_d <= LOAD_STROBE_N;
      in_we <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        OUT_GND_1K[k] <= POWER_MODE[2*k +: 2] == `ODAC_PM_1K;
        OUT_TRISTATE[k] <= POWER_MODE[2*k +: 2] == `ODAC_PM_TRI;
      end
      // one channel copied per cycle; input read is a registered port
      if (copy_pend) begin
        copy_ch <= copy_ch + 3'h1;
        if (copy_ch == 3'h7) begin
          copy_pend <= 1'b0;
        end
      end
      // dac writes are not gated by power mode
      if (copy_pend && copy_ch != 3'h0 && copy_set[copy_ch-3'h1]) begin
        DAC_CODE[(copy_ch-3'h1)*DW +: DW] <= in_rdata;
      end
      if (!copy_pend && copy_ch == 3'h0 && copy_set[7]) begin
        DAC_CODE[7*DW +: DW] <= in_rdata;
        copy_set <= {NCH{1'b0}};
      end
      // requests meeting a busy engine are queued, not dropped
      if (copy_pend) begin
        copy_more <= copy_more | copy_req;
      end else if ((copy_req | copy_more) != {NCH{1'b0}}) begin
        copy_set <= copy_req | copy_more;
        copy_pend <= 1'b1;
        copy_ch <= 3'h0;
        copy_more <= {NCH{1'b0}};
      end
      if (frame_go) begin
        case (f_cmd)
          `ODAC_CMD_WR_IN: begin
            // input write, transparent while strobe low
            in_we <= ~f_adr[3];
            in_waddr <= f_adr[2:0];
            in_wdata <= f_dat;
            if (!LOAD_STROBE_N && !LOAD_MASK[f_adr[2:0]] && !f_adr[3]) begin
              DAC_CODE[f_adr[2:0]*DW +: DW] <= f_dat;
            end
          end
          `ODAC_CMD_UPD: begin
            // picked up by the copy request
            in_we <= 1'b0;
          end
          `ODAC_CMD_WR_UPD: begin
            in_we <= ~f_adr[3];
            in_waddr <= f_adr[2:0];
            in_wdata <= f_dat;
            if (!f_adr[3]) begin
              DAC_CODE[f_adr[2:0]*DW +: DW] <= f_dat;
            end
          end
          `ODAC_CMD_PWR: begin
            POWER_MODE <= f_dat;
          end
          `ODAC_CMD_MASK: begin
            LOAD_MASK <= f_sel;
          end
          default: begin
            in_we <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* sim/odac_port_monitor.sv */
// checker on the port pins of the two-wire dac command port
// assumes a slow bus: each scl half period spans at least six clocks
`timescale 1ns/1ns
module odac_port_monitor #(
  parameter DW = 16,
  parameter NCH = 8
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire LOAD_STROBE_N,
  input wire [NCH*DW-1:0] DAC_CODE,
  input wire [2*NCH-1:0] POWER_MODE,
  input wire [NCH-1:0] OUT_GND_1K,
  input wire [NCH-1:0] OUT_TRISTATE,
  input wire [NCH-1:0] LOAD_MASK
);
  reg [3:0] since;
  reg ld_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // age of the last sda drive or strobe fall, saturating
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      since <= 4'hf;
      ld_q <= 1'b1;
    end else begin
      ld_q <= LOAD_STROBE_N;
      if (SDA_OE || (ld_q && !LOAD_STROBE_N)) begin
        since <= 4'h0;
      end else if (since != 4'hf) begin
        since <= since + 4'h1;
      end
    end
  end
  property p_drv_low; SDA_OE |-> !SDA_OUT; endproperty
  a_drv_low: assert property (p_drv_low) else $error("sda driven high");
  property p_oe_chg; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe_chg: assert property (p_oe_chg) else $error("sda moved while scl high");
  property p_ack_hold; $rose(SDA_OE) |-> SDA_OE [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda drive too short");
  property p_start; SCL_IN && $fell(SDA_IN) && !SDA_OE |-> !SDA_OE [*8]; endproperty
  a_start: assert property (p_start) else $error("drive during address");
  property p_gnd; OUT_GND_1K[0] == ($past(POWER_MODE[1:0]) == 2'h1); endproperty
  a_gnd: assert property (p_gnd) else $error("ground mode decode");
  property p_tri; OUT_TRISTATE[7] == ($past(POWER_MODE[15:14]) == 2'h3); endproperty
  a_tri: assert property (p_tri) else $error("tristate decode");
  property p_mask; $changed(LOAD_MASK) |-> !SCL_IN; endproperty
  a_mask: assert property (p_mask) else $error("mask changed off frame end");
  property p_pwr; $changed(POWER_MODE) |-> !SCL_IN; endproperty
  a_pwr: assert property (p_pwr) else $error("power changed off frame end");
  property p_dac; $changed(DAC_CODE) |-> since < 4'hc; endproperty
  a_dac: assert property (p_dac) else $error("dac changed without cause");
  c_strobe: cover property ($fell(LOAD_STROBE_N));
  c_ack: cover property ($rose(SDA_OE));
  c_pwr: cover property ($changed(POWER_MODE));
endmodule
bind odac_i2c_port odac_port_monitor #(.DW(DW), .NCH(NCH)) odac_port_monitor_inst (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .LOAD_STROBE_N(LOAD_STROBE_N), .DAC_CODE(DAC_CODE),
  .POWER_MODE(POWER_MODE), .OUT_GND_1K(OUT_GND_1K), .OUT_TRISTATE(OUT_TRISTATE),
  .LOAD_MASK(LOAD_MASK));

/* sim/odac_bus_master.sv */
// two-wire bus master model, tasks called by the bench
// assumes the bench resolves sda as a wired line with a pull-up
`timescale 1ns/1ns
module odac_bus_master (
  input wire clk,
  input wire sda_in,
  output reg scl,
  output reg sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // six clocks per half period, slow against the port
  task hp;
    repeat (6) @(negedge clk);
  endtask
  // start, also repeated start from scl low
  task start;
    @(negedge clk);
    sda = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  // stop: low then released while scl high
  task stop;
    @(negedge clk);
    sda = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda = 1'b1;
    hp;
  endtask
  // data moves only while scl is low
  task bit_io(input b, output r);
    @(negedge clk);
    sda = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda_in;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the ninth pulse
  task xfer(input [7:0] w, input last, output [7:0] r, output ack);
    integer i;
    reg b;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_io(w[i], b);
      r[i] = b;
    end
    bit_io(last, ack);
  endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the two-wire dac command port
// master model drives scl and sda; sda is wired-and with pull-up
`timescale 1ns/1ns
module tb_top;
  reg sys_clk, rst_b, strobe_n, ak;
  reg [1:0] pins;
  reg [7:0] rb;
  wire scl, m_sda, sda_oe, sda_out;
  wire sda = m_sda & (~sda_oe | sda_out);
  wire [127:0] dac;
  wire [15:0] pm;
  wire [7:0] gnd1k, tri_s, mask;
  integer n_errors = 0;
  integer tests_run = 0;
  odac_i2c_port odac_i2c_port_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_PIN_HI(pins[1]),
    .ADDR_SELECT_PIN_LO(pins[0]), .LOAD_STROBE_N(strobe_n), .DAC_CODE(dac),
    .POWER_MODE(pm), .OUT_GND_1K(gnd1k), .OUT_TRISTATE(tri_s), .LOAD_MASK(mask));
  odac_bus_master odac_bus_master_inst (.clk(sys_clk), .sda_in(sda), .scl(scl), .sda(m_sda));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function [15:0] ch(input [2:0] n);
    ch = dac[16*n +: 16];
  endfunction
  task chk(input [127:0] g, input [127:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wb(input [7:0] b);
    odac_bus_master_inst.xfer(b, 1'b1, rb, ak);
    chk(ak, 1'b0);
  endtask
  task frame(input [3:0] c, input [3:0] a, input [15:0] d, input sp);
    odac_bus_master_inst.start;
    wb({5'h03, pins, 1'b0});
    wb({c, a});
    wb(d[15:8]);
    wb(d[7:0]);
    if (sp) begin
      odac_bus_master_inst.stop;
    end
  endtask
  task s_addr;
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      pins = i[1:0];
      frame(4'h3, i[3:0], {4{4'h1 + i[3:0]}}, 1'b1);
      chk(ch(i[2:0]), {4{4'h1 + i[3:0]}});
    end
    odac_bus_master_inst.start;
    odac_bus_master_inst.xfer({5'h03, ~pins, 1'b0}, 1'b1, rb, ak);
    chk(ak, 1'b1);
    odac_bus_master_inst.stop;
  endtask
  task s_strobe;
    frame(4'h1, 4'h5, 16'hbeef, 1'b1);
    chk(ch(5), 16'h0);
    strobe_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(ch(5), 16'hbeef);
    frame(4'h1, 4'h6, 16'hcafe, 1'b1);
    chk(ch(6), 16'hcafe);
    strobe_n = 1'b1;
  endtask
  task s_mask;
    frame(4'h5, 4'h0, 16'h0020, 1'b1);
    chk(mask, 8'h20);
    frame(4'h1, 4'h5, 16'h1234, 1'b1);
    frame(4'h1, 4'h6, 16'h5555, 1'b1);
    strobe_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(ch(5), 16'hbeef);
    strobe_n = 1'b1;
    frame(4'h1, 4'h6, 16'h6666, 1'b1);
    frame(4'h2, 4'h0, 16'h0020, 1'b1);
    chk({ch(6), ch(5)}, {16'h5555, 16'h1234});
  endtask
  task s_pwr;
    frame(4'h4, 4'h0, 16'hc001, 1'b1);
    chk({tri_s, gnd1k, pm}, 32'h8001c001);
    frame(4'h3, 4'h0, 16'h7777, 1'b1);
    chk(ch(0), 16'h7777);
    frame(4'h8, 4'h0, 16'hffff, 1'b1);
    chk({pm, ch(0), mask}, {16'hc001, 16'h7777, 8'h20});
  endtask
  task s_read(input [3:0] p, input integer n, input [31:0] e);
    integer i;
    reg [31:0] got;
    got = 32'h0;
    frame(4'h1, 4'h7, 16'ha55a, 1'b1);
    frame(4'h1, 4'h0, 16'h0ff0, 1'b1);
    frame(4'h9, p, 16'h0, 1'b0);
    odac_bus_master_inst.start;
    wb({5'h03, pins, 1'b1});
    for (i = 0; i < n; i = i + 1) begin
      odac_bus_master_inst.xfer(8'hff, i == n - 1, rb, ak);
      got = {got[23:0], rb};
    end
    odac_bus_master_inst.stop;
    chk(got, e);
  endtask
  initial begin
    rst_b = 1'b0;
    strobe_n = 1'b1;
    pins = 2'h0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(dac, 128'h0);
    chk({gnd1k, tri_s, pm, mask, sda_oe}, 128'h0);
    s_addr;
    s_strobe;
    s_mask;
    s_pwr;
    s_read(4'h7, 4, 32'ha55a0ff0);
    s_read(4'h8, 2, 32'h00000ff0);
    complete_run;
  end
  // hang guard, about 50000 clocks
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    $display("mismatch at %0t: run too long", $time);
    complete_run;
  end
endmodule
